// [inc/pmc_pkg.sv]
// Constants, layouts and types of the power mode control block
package pmc_pkg;
   // Oscillator periods per machine cycle and per ALE period
   localparam int PMC_MC_CLKS  = 12;
   localparam int PMC_PH_HALF  = 6;
   localparam int PMC_PH_W     = 4;
   // Phase windows inside one half machine cycle
   localparam int PMC_ALE_LEN  = 2;
   localparam int PMC_ADDR_LEN = 3;
   localparam int PMC_PROGRAM_FETCH_STROBE_ON  = 3;
   // Reset pin must stay high for this many machine cycles
   localparam int PMC_RST_MC   = 2;
   localparam int PMC_RST_CLKS = PMC_MC_CLKS * PMC_RST_MC;
   localparam int PMC_RCNT_W   = 5;
   // Register map
   localparam logic [7:0] PMC_POWER_CONTROL_REG_ADDR  = 8'h00;
   localparam logic [7:0] PMC_STAT_ADDR  = 8'h01;
   localparam logic [7:0] PMC_POWER_CONTROL_REG_RST   = 8'h00;
   localparam logic [7:0] PMC_POWER_CONTROL_REG_WMASK = 8'h8f;
   localparam logic [7:0] PMC_RD_NONE    = 8'h00;
   localparam logic [1:0] PMC_WAKE_IDLE  = 2'h3;
   localparam logic [2:0] PMC_SYNC_RST   = 3'h3;

   typedef logic [PMC_PH_W-1:0]   pmc_phase_t;
   typedef logic [PMC_RCNT_W-1:0] pmc_rcnt_t;

   typedef enum logic [1:0] {
      PMC_NORMAL,
      PMC_IDLE,
      PMC_DOWN,
      PMC_WAKE
   } pmc_mode_e;

   typedef struct packed {
      logic       baud_doubler;
      logic [2:0] reserved;
      logic       user_flag_one;
      logic       user_flag_zero;
      logic       deep_sleep_request;
      logic       light_sleep_request;
   } pmc_power_control_reg_s;

   typedef struct packed {
      logic [3:0] zero;
      logic       osc_run;
      logic       cpu_run;
      pmc_mode_e  mode;
   } pmc_stat_s;

   // External data access of the next machine cycle
   typedef struct packed {
      logic        data_cyc;
      logic        wide;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pmc_xdata_s;
endpackage : pmc_pkg

// [hdl/pmc_sync.sv]
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pmc_sync #(
   parameter int           W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Pins
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q_ff
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= RST_VAL;
         q_ff    <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end
endmodule : pmc_sync

// [hdl/pmc_phase_gen.sv]
// Machine cycle phase counter
`timescale 1ns/1ps
module pmc_phase_gen #(
   parameter int N = 12,
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Control
   input  wire logic         run,
   output      logic [W-1:0] phase_ff,
   output      logic         last
);
   localparam logic [W-1:0] LAST = W'(N - 1);
   localparam logic [W-1:0] ONE  = W'(1);

   assign last = run && (phase_ff == LAST);

   // Counter freezes while the oscillator is stopped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= '0;
      end else if (last) begin
         phase_ff <= '0;
      end else if (run) begin
         phase_ff <= phase_ff + ONE;
      end
   end
endmodule : pmc_phase_gen

// [hdl/pmc_power_mode_control.sv]
// Power mode control: power register, idle, power-down and memory strobes
`timescale 1ns/1ps
module pmc_power_mode_control
   import pmc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [7:0]  reg_rdata_ff,
   // Pins
   input  wire logic        reset_pin,
   input  wire logic        wake_irq_zero_n,
   input  wire logic        wake_irq_one_n,
   input  wire logic        external_fetch_enable_n,
   output      logic        address_latch_strobe_ff,
   output      logic        program_fetch_strobe_n_ff,
   output      logic [7:0]  port0_out_ff,
   output      logic        port0_oe_n_ff,
   output      logic [7:0]  upper_port_ff,
   // Core side
   input  wire logic [15:0] fetch_addr,
   input  wire pmc_xdata_s  xdata_req,
   input  wire logic [7:0]  upper_port_latch,
   input  wire logic        wake_en_zero,
   input  wire logic        wake_en_one,
   input  wire logic        irq_pending,
   input  wire logic        irq_take,
   output      logic        cpu_clk_en_ff,
   output      logic        periph_clk_en_ff,
   output      logic        osc_run_ff,
   output      logic        sfr_reset_ff,
   output      logic        baud_doubler_ff
);
   pmc_power_control_reg_s  power_control_reg_ff;
   pmc_mode_e  mode_ff;
   pmc_mode_e  nxt_mode;
   pmc_xdata_s xreq_ff;
   pmc_stat_s  stat;
   pmc_phase_t phase;
   pmc_phase_t half_ph;
   pmc_rcnt_t  rcnt_ff;
   logic [2:0] pins_s;
   logic [1:0] armed_ff;
   logic [1:0] wake_low;
   logic       rst_s;
   logic       last_ph;
   logic       wr_power_control_reg;
   logic       ext_fetch;
   logic       normal;

   // Wake and reset pins resynchronised
   // pin resynchronisation
   pmc_sync #(
      .W       (3),
      .RST_VAL (PMC_SYNC_RST)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({reset_pin, wake_irq_one_n, wake_irq_zero_n}),
      .q_ff    (pins_s)
   );

   pmc_phase_gen #(
      .N       (PMC_MC_CLKS),
      .W       (PMC_PH_W)
   ) u_phase (
      .clk      (clk),
      .reset_n  (reset_n),
      .run      (osc_run_ff),
      .phase_ff (phase),
      .last     (last_ph)
   );

   assign rst_s     = pins_s[2];
   assign wake_low  = {wake_en_one & ~pins_s[1], wake_en_zero & ~pins_s[0]};
   assign wr_power_control_reg   = reg_wr && (reg_addr == PMC_POWER_CONTROL_REG_ADDR);
   assign ext_fetch = !external_fetch_enable_n;
   assign normal    = (mode_ff == PMC_NORMAL);
   assign half_ph   = (phase >= pmc_phase_t'(PMC_PH_HALF)) ? pmc_phase_t'(phase - pmc_phase_t'(PMC_PH_HALF)) : phase;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rcnt_ff <= '0;
      end else if (!rst_s) begin
         rcnt_ff <= '0;
      end else if (rcnt_ff != pmc_rcnt_t'(PMC_RST_CLKS)) begin
         rcnt_ff <= rcnt_ff + pmc_rcnt_t'(1);
      end
   end

   // register reinit while the pin stays high past two machine cycles
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_reset_ff <= 1'b1;
      end else begin
         sfr_reset_ff <= rst_s && (rcnt_ff == pmc_rcnt_t'(PMC_RST_CLKS));
      end
   end

   // Register reset wins over a software write, which wins over an interrupt clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_control_reg_ff <= PMC_POWER_CONTROL_REG_RST;
      end else if (sfr_reset_ff) begin
         power_control_reg_ff <= PMC_POWER_CONTROL_REG_RST;
      end else if (wr_power_control_reg) begin
         power_control_reg_ff <= reg_wdata & PMC_POWER_CONTROL_REG_WMASK;
      end else if (irq_take) begin
         power_control_reg_ff.deep_sleep_request  <= 1'b0;
         power_control_reg_ff.light_sleep_request <= 1'b0;
      end else if (mode_ff == PMC_IDLE && irq_pending) begin
         power_control_reg_ff.light_sleep_request <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         baud_doubler_ff <= 1'b0;
      end else begin
         baud_doubler_ff <= power_control_reg_ff.baud_doubler;
      end
   end

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         PMC_NORMAL: begin
            if (wr_power_control_reg && reg_wdata[1]) begin
               nxt_mode = PMC_DOWN;
            end else if (wr_power_control_reg && reg_wdata[0]) begin
               nxt_mode = PMC_IDLE;
            end
         end
         PMC_IDLE: begin
            if (irq_pending) begin
               nxt_mode = PMC_NORMAL;
            end
         end
         PMC_DOWN: begin
            if (|wake_low) begin
               nxt_mode = PMC_WAKE;
            end
         end
         PMC_WAKE: begin
            if (|(armed_ff & ~wake_low)) begin
               nxt_mode = PMC_NORMAL;
            end
         end
         default: begin
            nxt_mode = PMC_NORMAL;
         end
      endcase
      // reset ends any low power mode
      if (sfr_reset_ff) begin
         nxt_mode = PMC_NORMAL;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= PMC_NORMAL;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Pins low while stopped or waking are the ones whose release counts
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_ff <= '0;
      end else if (mode_ff == PMC_DOWN || mode_ff == PMC_WAKE) begin
         armed_ff <= armed_ff | wake_low;
      end else begin
         armed_ff <= '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_clk_en_ff    <= 1'b1;
         periph_clk_en_ff <= 1'b1;
         osc_run_ff       <= 1'b1;
      end else begin
         cpu_clk_en_ff    <= (nxt_mode == PMC_NORMAL);
         periph_clk_en_ff <= (nxt_mode == PMC_NORMAL) || (nxt_mode == PMC_IDLE);
         osc_run_ff       <= (nxt_mode != PMC_DOWN);
      end
   end

   // Access requested for the coming machine cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xreq_ff <= '0;
      end else if (last_ph) begin
         xreq_ff <= normal ? xdata_req : '0;
      end
   end

   // Strobes follow the phase one cycle late
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         address_latch_strobe_ff   <= 1'b0;
         program_fetch_strobe_n_ff <= 1'b1;
      end else begin
         case (mode_ff)
            PMC_NORMAL: begin
               // second pulse skipped in data cycle
               address_latch_strobe_ff   <= (half_ph < pmc_phase_t'(PMC_ALE_LEN)) &&
                                            !(xreq_ff.data_cyc && phase >= pmc_phase_t'(PMC_PH_HALF));
               // two fetch strobes, both skipped for data
               program_fetch_strobe_n_ff <= !(ext_fetch && !xreq_ff.data_cyc &&
                                              half_ph >= pmc_phase_t'(PMC_PROGRAM_FETCH_STROBE_ON));
            end
            PMC_IDLE: begin
               address_latch_strobe_ff   <= 1'b1;
               program_fetch_strobe_n_ff <= 1'b1;
            end
            default: begin
               address_latch_strobe_ff   <= 1'b0;
               program_fetch_strobe_n_ff <= 1'b0;
            end
         endcase
      end
   end

   // low address then data on port zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port0_out_ff  <= '0;
         port0_oe_n_ff <= 1'b1;
      end else if (!normal) begin
         port0_oe_n_ff <= 1'b1;
      end else if (xreq_ff.data_cyc) begin
         if (phase < pmc_phase_t'(PMC_ADDR_LEN)) begin
            port0_out_ff  <= xreq_ff.addr[7:0];
            port0_oe_n_ff <= 1'b0;
         end else begin
            port0_out_ff  <= xreq_ff.wdata;
            port0_oe_n_ff <= !xreq_ff.write;
         end
      end else if (ext_fetch && half_ph < pmc_phase_t'(PMC_ADDR_LEN)) begin
         port0_out_ff  <= fetch_addr[7:0];
         port0_oe_n_ff <= 1'b0;
      end else begin
         port0_oe_n_ff <= 1'b1;
      end
   end

   // Idle freezes the upper port at its last value
   // upper address byte or latched contents
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_port_ff <= '0;
      end else if (mode_ff == PMC_IDLE) begin
         upper_port_ff <= upper_port_ff;
      end else if (!normal) begin
         upper_port_ff <= upper_port_latch;
      end else if (xreq_ff.data_cyc) begin
         upper_port_ff <= xreq_ff.wide ? xreq_ff.addr[15:8] : upper_port_latch;
      end else begin
         upper_port_ff <= ext_fetch ? fetch_addr[15:8] : upper_port_latch;
      end
   end

   // flags read back, no hardware effect
   assign stat = '{zero: 4'h0, osc_run: osc_run_ff, cpu_run: cpu_clk_en_ff, mode: mode_ff};
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_ff <= PMC_RD_NONE;
      end else if (reg_rd && reg_addr == PMC_POWER_CONTROL_REG_ADDR) begin
         reg_rdata_ff <= power_control_reg_ff & PMC_POWER_CONTROL_REG_WMASK;
      end else if (reg_rd && reg_addr == PMC_STAT_ADDR) begin
         reg_rdata_ff <= stat;
      end else begin
         reg_rdata_ff <= PMC_RD_NONE;
      end
   end

   // Helper: consecutive cycles of synchronised reset pin high
   int hold_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_q <= 0;
      end else begin
         hold_q <= rst_s ? hold_q + 1 : 0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_norm2;
      (mode_ff == PMC_NORMAL) [*2];
   endsequence
   sequence s_ale_pulse;
      address_latch_strobe_ff ##1 !address_latch_strobe_ff;
   endsequence

   a_reset_hold_len: assert property ($rose(sfr_reset_ff) |-> hold_q >= PMC_RST_CLKS)
      else $error("register reset before pin held two machine cycles");
   a_ale_rate: assert property ((phase == 0 && !xreq_ff.data_cyc && normal) ##1 s_norm2 |-> s_ale_pulse)
      else $error("address strobe not two periods wide at cycle start");
   a_ale_skip: assert property (xreq_ff.data_cyc && normal && phase == 6 |=> !address_latch_strobe_ff)
      else $error("address strobe not skipped in data cycle");
   a_program_fetch_strobe_twice: assert property (ext_fetch && normal && !xreq_ff.data_cyc && half_ph == 3 |=> !program_fetch_strobe_n_ff)
      else $error("fetch strobe missing on external fetch");
   a_program_fetch_strobe_internal: assert property (!ext_fetch && normal |=> program_fetch_strobe_n_ff)
      else $error("fetch strobe active for internal fetch");
   a_p2_narrow: assert property (normal && xreq_ff.data_cyc && !xreq_ff.wide |=> upper_port_ff == $past(upper_port_latch))
      else $error("upper port not showing latch on short access");
   a_p0_addr: assert property (normal && phase == 0 && xreq_ff.data_cyc |=> !port0_oe_n_ff && port0_out_ff == $past(xreq_ff.addr[7:0]))
      else $error("low data address not driven on port zero");
   // Write data follows the address on the same pins
   a_p0_data: assert property (normal && phase == PMC_ADDR_LEN && xreq_ff.data_cyc && xreq_ff.write |=> !port0_oe_n_ff && port0_out_ff == $past(xreq_ff.wdata))
      else $error("write data not driven on port zero");
   a_power_control_reg_reset: assert property (sfr_reset_ff |=> power_control_reg_ff == PMC_POWER_CONTROL_REG_RST && mode_ff == PMC_NORMAL)
      else $error("power register or mode not cleared by reset");
   a_idle_gate: assert property (mode_ff == PMC_IDLE |-> !cpu_clk_en_ff && periph_clk_en_ff)
      else $error("idle clock gating wrong");
   a_idle_strobes: assert property (mode_ff == PMC_IDLE |=> address_latch_strobe_ff && program_fetch_strobe_n_ff)
      else $error("strobes not high in idle");
   a_idle_exit: assert property (mode_ff == PMC_IDLE && irq_pending && !wr_power_control_reg |=> normal && !power_control_reg_ff.light_sleep_request)
      else $error("interrupt did not end idle");
   a_down_strobes: assert property (mode_ff == PMC_DOWN && !(|wake_low) && !sfr_reset_ff |=> !address_latch_strobe_ff && !program_fetch_strobe_n_ff && !osc_run_ff)
      else $error("power-down outputs wrong");
   a_wake_restart: assert property (mode_ff == PMC_DOWN && |wake_low && !sfr_reset_ff |=> mode_ff == PMC_WAKE && osc_run_ff)
      else $error("wake pin did not restart oscillator");
   a_both_clear: assert property (irq_take && !wr_power_control_reg && !sfr_reset_ff |=> !power_control_reg_ff.deep_sleep_request && !power_control_reg_ff.light_sleep_request)
      else $error("vectoring left a sleep request set");
endmodule : pmc_power_mode_control

// [tb/pmc_ext_mem.sv]
// External memory side: port 0 wire and address latch
`timescale 1ns/1ps
module pmc_ext_mem (
   // Clock
   input  wire logic       clk,
   // Block outputs
   input  wire logic       ale,
   input  wire logic [7:0] p0_out,
   input  wire logic       p0_oe_n,
   // Observed wire and latched address
   output      logic [7:0] p0_wire,
   output      logic [7:0] latched_lo
);
   logic [7:0] last_ff;

   // Port 0 has no pull-up, so a floating bus shows the inverse of its last value
   always_ff @(posedge clk) begin
      if (!p0_oe_n) begin
         last_ff <= p0_out;
      end
   end

   always_comb begin
      p0_wire = p0_oe_n ? ~last_ff : p0_out;
   end

   always @(negedge ale) begin
      latched_lo = p0_wire;
   end
endmodule : pmc_ext_mem

// [tb/tb_top.sv]
// Testbench of the power mode control block
`timescale 1ns/1ps
module tb_top;
   import pmc_pkg::*;
   logic        clk, reset_n, reg_wr, reg_rd, reset_pin, wake_irq_zero_n, wake_irq_one_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff, port0_out_ff, upper_port_ff, upper_port_latch;
   logic        external_fetch_enable_n, address_latch_strobe_ff, program_fetch_strobe_n_ff, port0_oe_n_ff;
   logic [15:0] fetch_addr;
   pmc_xdata_s  xdata_req;
   logic        wake_en_zero, wake_en_one, irq_pending, irq_take, cpu_clk_en_ff, periph_clk_en_ff;
   logic        osc_run_ff, sfr_reset_ff, baud_doubler_ff;
   logic [7:0]  p0_wire, latched_lo;
   int          failures, total_checks, cycles, n_ale, n_fs;

   pmc_power_mode_control pmc_power_mode_control_inst (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reset_pin(reset_pin),
      .wake_irq_zero_n(wake_irq_zero_n), .wake_irq_one_n(wake_irq_one_n),
      .external_fetch_enable_n(external_fetch_enable_n), .address_latch_strobe_ff(address_latch_strobe_ff),
      .program_fetch_strobe_n_ff(program_fetch_strobe_n_ff), .port0_out_ff(port0_out_ff),
      .port0_oe_n_ff(port0_oe_n_ff), .upper_port_ff(upper_port_ff), .fetch_addr(fetch_addr),
      .xdata_req(xdata_req), .upper_port_latch(upper_port_latch), .wake_en_zero(wake_en_zero),
      .wake_en_one(wake_en_one), .irq_pending(irq_pending), .irq_take(irq_take),
      .cpu_clk_en_ff(cpu_clk_en_ff), .periph_clk_en_ff(periph_clk_en_ff), .osc_run_ff(osc_run_ff),
      .sfr_reset_ff(sfr_reset_ff), .baud_doubler_ff(baud_doubler_ff));

   pmc_ext_mem pmc_ext_mem_inst (
      .clk(clk), .ale(address_latch_strobe_ff), .p0_out(port0_out_ff), .p0_oe_n(port0_oe_n_ff),
      .p0_wire(p0_wire), .latched_lo(latched_lo));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task finish_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Whole run needs well under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check(name, reg_rdata_ff, exp);
   endtask : rdc

   task count(input int n);
      logic pa;
      logic pf;
      n_ale = 0;
      n_fs  = 0;
      pa    = address_latch_strobe_ff;
      pf    = program_fetch_strobe_n_ff;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (address_latch_strobe_ff && !pa) n_ale++;
         if (!program_fetch_strobe_n_ff && pf) n_fs++;
         pa = address_latch_strobe_ff;
         pf = program_fetch_strobe_n_ff;
      end
   endtask : count

   task automatic wait_lvl(ref logic s, input logic v, input int lim, input string name);
      int i;
      i = 0;
      while (s !== v && i < lim) begin
         @(posedge clk);
         #1;
         i++;
      end
      check(name, s, v);
   endtask : wait_lvl

   task pulse_irq(input logic take);
      @(posedge clk);
      if (take) irq_take <= 1'b1;
      else irq_pending <= 1'b1;
      @(posedge clk);
      irq_take    <= 1'b0;
      irq_pending <= 1'b0;
      cyc(2);
   endtask : pulse_irq

   initial begin
      {reg_wr, reg_rd, reset_pin, irq_pending, irq_take, wake_en_zero, wake_en_one} = '0;
      {reg_addr, reg_wdata} = '0;
      {wake_irq_zero_n, wake_irq_one_n} = 2'h3;
      external_fetch_enable_n = 1'b0;
      fetch_addr       = 16'h5a3c;
      upper_port_latch = 8'h77;
      xdata_req        = '0;
      reset_n          = 1'b0;
      cycles           = 0;
      failures         = 0;
      total_checks     = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      cyc(4);
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h00, "power_control_reg reset");
      rdc(PMC_STAT_ADDR, 8'h0c, "status reset");
      wr(PMC_POWER_CONTROL_REG_ADDR, 8'hfc);
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h8c, "power_control_reg flags");
      wr(8'h05, 8'hff);
      rdc(8'h05, 8'h00, "unmapped");
      wr(PMC_STAT_ADDR, 8'hff);
      rdc(PMC_STAT_ADDR, 8'h0c, "status ro");
      check("baud", baud_doubler_ff, 1'b1);
      // Windows are whole machine cycles so alignment cannot change the counts
      cyc(24);
      count(120);
      check("ale fetch", n_ale, 20);
      check("strobe fetch", n_fs, 20);
      check("upper fetch", upper_port_ff, 8'h5a);
      check("low addr fetch", latched_lo, 8'h3c);
      @(posedge clk);
      xdata_req <= '{1'b1, 1'b0, 1'b1, 16'hab12, 8'h99};
      cyc(24);
      count(120);
      check("ale data", n_ale, 10);
      check("strobe data", n_fs, 0);
      check("upper short", upper_port_ff, 8'h77);
      check("low addr data", latched_lo, 8'h12);
      @(posedge clk);
      xdata_req <= '{1'b1, 1'b1, 1'b0, 16'hab12, 8'h99};
      cyc(24);
      check("upper wide", upper_port_ff, 8'hab);
      @(posedge clk);
      xdata_req <= '0;
      external_fetch_enable_n <= 1'b1;
      cyc(24);
      count(120);
      check("strobe internal", n_fs, 0);
      check("ale internal", n_ale, 20);
      @(posedge clk);
      external_fetch_enable_n <= 1'b0;
      cyc(24);
      wr(PMC_POWER_CONTROL_REG_ADDR, 8'h8d);
      rdc(PMC_STAT_ADDR, 8'h09, "idle status");
      check("periph run", periph_clk_en_ff, 1'b1);
      count(24);
      check("idle ale", {n_ale[7:0], address_latch_strobe_ff, program_fetch_strobe_n_ff}, 10'h3);
      check("idle upper", upper_port_ff, 8'h5a);
      pulse_irq(1'b0);
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h8c, "idle bit clear");
      rdc(PMC_STAT_ADDR, 8'h0c, "idle end");
      wr(PMC_POWER_CONTROL_REG_ADDR, 8'h8f);
      rdc(PMC_STAT_ADDR, 8'h02, "down status");
      check("down pins", {address_latch_strobe_ff, program_fetch_strobe_n_ff, osc_run_ff}, 3'h0);
      pulse_irq(1'b0);
      @(posedge clk);
      wake_irq_one_n <= 1'b0;
      wake_en_zero   <= 1'b1;
      cyc(8);
      rdc(PMC_STAT_ADDR, 8'h02, "no wake");
      @(posedge clk);
      wake_irq_one_n  <= 1'b1;
      wake_irq_zero_n <= 1'b0;
      wait_lvl(osc_run_ff, 1'b1, 8, "osc restart");
      rdc(PMC_STAT_ADDR, 8'h0b, "wake status");
      @(posedge clk);
      wake_irq_zero_n <= 1'b1;
      wait_lvl(cpu_clk_en_ff, 1'b1, 8, "exit done");
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h8f, "power_control_reg kept");
      check("no sfr reset", sfr_reset_ff, 1'b0);
      pulse_irq(1'b1);
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h8c, "both cleared");
      rdc(PMC_STAT_ADDR, 8'h0c, "no idle");
      // A short reset pulse must not reset the device
      @(posedge clk);
      reset_pin <= 1'b1;
      cyc(20);
      reset_pin <= 1'b0;
      cyc(6);
      check("short pulse", sfr_reset_ff, 1'b0);
      wr(PMC_POWER_CONTROL_REG_ADDR, 8'h0d);
      @(posedge clk);
      reset_pin <= 1'b1;
      cyc(24);
      #1;
      check("reset early", sfr_reset_ff, 1'b0);
      wait_lvl(sfr_reset_ff, 1'b1, 8, "reset taken");
      @(posedge clk);
      reset_pin <= 1'b0;
      wait_lvl(sfr_reset_ff, 1'b0, 8, "reset release");
      rdc(PMC_POWER_CONTROL_REG_ADDR, 8'h00, "power_control_reg cleared");
      rdc(PMC_STAT_ADDR, 8'h0c, "idle reset end");
      finish_test();
   end
endmodule : tb_top
